// ### hdl/pwrseq.sv
`timescale 1ns/10ps
module pwrseq #(
	parameter int CAL_MAX_CYC = pwrseq_pkg::CAL_MAX_CYC,
	parameter int VCO_MAX_CYC = pwrseq_pkg::VCO_MAX_CYC,
	parameter int CAL_JC_CYC = pwrseq_pkg::CAL_JC_CYC
) (
	input wire logic CLOCK_IN,
	input wire logic NRST_IN,
	input wire logic CE_IN,
	input wire pwrseq_pkg::bus_req_t BUS_REQ_IN,
	output logic [31:0] RDATA_OUT,
	input wire logic POWER_DOWN_N_IN,
	input wire logic POR_OK_IN,
	input wire logic XTAL_AMP_OK_IN,
	input wire logic [1:0] PLL_LOCK_IN,
	input wire logic PFD_CLK_IN,
	input wire pwrseq_pkg::cfg_pins_t CFG_PINS_IN,
	output logic [1:0] PLL_OUT_EN_OUT,
	output logic STATUS_A_OUT,
	output logic STATUS_B_OUT,
	output logic I2C_EN_OUT
);

	localparam int W = pwrseq_pkg::CNT_W;

	// Synchroniser stages and PFD and power-down pin edge history
	logic [pwrseq_pkg::SY_W-1:0] raw_in;
	logic [pwrseq_pkg::SY_W-1:0] sync1_q;
	logic [pwrseq_pkg::SY_W-1:0] sync2_q;
	logic pfd_prev_q;
	logic pdn_prev_q;

	// Decoded pin levels, all after two flops
	logic pd;
	logic por_ok;
	logic xo_ok;
	logic pfd_edge;
	logic pdn_rise;

	// Register file
	logic [7:0] ctrl_q;
	logic [1:0][W-1:0] cal_cnt_q;
	logic [1:0][W-1:0] vco_cnt_q;
	logic soft_q;
	logic [31:0] rdata_q;

	// Sequencer state
	pwrseq_pkg::top_state_t top_q;
	pwrseq_pkg::pll_state_t pll_q [2];
	logic [1:0][W-1:0] cnt_q;
	logic [1:0] en_q;
	logic [1:0] lol_q;
	logic [1:0] start;
	logic abort;
	logic par;
	logic all_done;
	logic [1:0] status_q;

	// Limits as counter-width values
	localparam logic [W-1:0] CAL_LO = W'(pwrseq_pkg::CAL_MIN_CYC);
	localparam logic [W-1:0] CAL_HI = W'(CAL_MAX_CYC);
	localparam logic [W-1:0] VCO_LO = W'(pwrseq_pkg::VCO_MIN_CYC);
	localparam logic [W-1:0] VCO_HI = W'(VCO_MAX_CYC);

	// Software counts are forced into the legal range
	function automatic logic [W-1:0] clamp_cnt(input logic [31:0] v,
		input logic [W-1:0] lo, input logic [W-1:0] hi);
		logic [W-1:0] r;
		r = v[W-1:0];
		if (v < 32'(lo)) begin
			r = lo;
		end else if (v > 32'(hi)) begin
			r = hi;
		end
		return r;
	endfunction

	// Status pin source select
	function automatic logic pick(input logic [1:0] sel,
		input logic [1:0] loss_of_lock, input logic done);
		logic r;
		r = 1'b0;
		case (sel)
			pwrseq_pkg::SEL_LOL1: r = loss_of_lock[0];
			pwrseq_pkg::SEL_LOL2: r = loss_of_lock[1];
			pwrseq_pkg::SEL_DONE: r = done;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	assign raw_in = {PFD_CLK_IN, PLL_LOCK_IN, XTAL_AMP_OK_IN, POR_OK_IN,
		POWER_DOWN_N_IN};

	// Two-flop synchronisers for the power-down, supply, crystal, lock and PFD pins; the straps are sampled directly
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else if (CE_IN) begin
			sync1_q <= raw_in;
			sync2_q <= sync1_q;
		end
	end

	// Edge history taken from the second stage only
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			pfd_prev_q <= 1'b0;
			pdn_prev_q <= 1'b0;
		end else if (CE_IN) begin
			pfd_prev_q <= sync2_q[pwrseq_pkg::SY_PFD];
			pdn_prev_q <= sync2_q[pwrseq_pkg::SY_PDN];
		end
	end

	assign pd = !sync2_q[pwrseq_pkg::SY_PDN];
	assign por_ok = sync2_q[pwrseq_pkg::SY_POR];
	assign xo_ok = sync2_q[pwrseq_pkg::SY_XO];
	assign pfd_edge = sync2_q[pwrseq_pkg::SY_PFD] & !pfd_prev_q;
	assign pdn_rise = sync2_q[pwrseq_pkg::SY_PDN] & !pdn_prev_q;
	assign par = ctrl_q[pwrseq_pkg::CTRL_PAR_START];

	// Register writes; straps reload on every pin release
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			ctrl_q <= pwrseq_pkg::CTRL_RST;
			cal_cnt_q[0] <= W'(pwrseq_pkg::CAL_CG_CYC);
			cal_cnt_q[1] <= W'(pwrseq_pkg::CAL_CG_CYC);
			vco_cnt_q[0] <= W'(pwrseq_pkg::VCO_REC_CYC);
			vco_cnt_q[1] <= W'(pwrseq_pkg::VCO_REC_CYC);
			soft_q <= 1'b0;
		end else if (CE_IN) begin
			soft_q <= 1'b0;
			if (pdn_rise) begin
				ctrl_q <= pwrseq_pkg::CTRL_RST;
				ctrl_q[pwrseq_pkg::CTRL_PAR_START] <= CFG_PINS_IN.par_start;
				ctrl_q[pwrseq_pkg::CTRL_XTAL_USED] <= CFG_PINS_IN.xtal_used;
				// jitter cleaner wants the long period
				if (CFG_PINS_IN.jitter_clean) begin
					cal_cnt_q[0] <= W'(CAL_JC_CYC);
					cal_cnt_q[1] <= W'(CAL_JC_CYC);
				end else begin
					cal_cnt_q[0] <= W'(pwrseq_pkg::CAL_CG_CYC);
					cal_cnt_q[1] <= W'(pwrseq_pkg::CAL_CG_CYC);
				end
				vco_cnt_q[0] <= W'(pwrseq_pkg::VCO_REC_CYC);
				vco_cnt_q[1] <= W'(pwrseq_pkg::VCO_REC_CYC);
			end else if (BUS_REQ_IN.wr && !pd) begin
				case (BUS_REQ_IN.addr)
					pwrseq_pkg::OFF_CTRL: begin
						ctrl_q <= BUS_REQ_IN.wdata[7:0];
						// Soft reset bit is a pulse, never stored
						ctrl_q[pwrseq_pkg::CTRL_SOFT_RST] <= 1'b0;
						soft_q <= BUS_REQ_IN.wdata[pwrseq_pkg::CTRL_SOFT_RST];
					end
					pwrseq_pkg::OFF_CAL1: cal_cnt_q[0] <=
						clamp_cnt(BUS_REQ_IN.wdata, CAL_LO, CAL_HI);
					pwrseq_pkg::OFF_VCO1: vco_cnt_q[0] <=
						clamp_cnt(BUS_REQ_IN.wdata, VCO_LO, VCO_HI);
					pwrseq_pkg::OFF_CAL2: cal_cnt_q[1] <=
						clamp_cnt(BUS_REQ_IN.wdata, CAL_LO, CAL_HI);
					pwrseq_pkg::OFF_VCO2: vco_cnt_q[1] <=
						clamp_cnt(BUS_REQ_IN.wdata, VCO_LO, VCO_HI);
					default: begin
						// Unmapped or read-only: ignored
					end
				endcase
			end
		end
	end

	// Read data one cycle after the strobe; zero while powered down
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			rdata_q <= '0;
		end else if (CE_IN) begin
			rdata_q <= '0;
			if (BUS_REQ_IN.rd && !pd) begin
				case (BUS_REQ_IN.addr)
					pwrseq_pkg::OFF_CTRL: rdata_q <= 32'(ctrl_q);
					pwrseq_pkg::OFF_CAL1: rdata_q <= 32'(cal_cnt_q[0]);
					pwrseq_pkg::OFF_VCO1: rdata_q <= 32'(vco_cnt_q[0]);
					pwrseq_pkg::OFF_CAL2: rdata_q <= 32'(cal_cnt_q[1]);
					pwrseq_pkg::OFF_VCO2: rdata_q <= 32'(vco_cnt_q[1]);
					pwrseq_pkg::OFF_STAT: rdata_q <= 32'({lol_q, en_q,
						pll_q[1], pll_q[0], top_q});
					default: rdata_q <= '0;
				endcase
			end
		end
	end

	// Top sequence: power-down, supply monitor, crystal
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			top_q <= pwrseq_pkg::TOP_OFF;
		end else if (CE_IN) begin
			if (pd) begin
				top_q <= pwrseq_pkg::TOP_OFF;
			end else if (!por_ok || soft_q) begin
				top_q <= pwrseq_pkg::TOP_POR;
			end else begin
				case (top_q)
					pwrseq_pkg::TOP_OFF: top_q <= pwrseq_pkg::TOP_POR;
					pwrseq_pkg::TOP_POR: top_q <= pwrseq_pkg::TOP_XO;
					pwrseq_pkg::TOP_XO: begin
						if (!ctrl_q[pwrseq_pkg::CTRL_XTAL_USED] || xo_ok) begin
							top_q <= pwrseq_pkg::TOP_GO;
						end
					end
					pwrseq_pkg::TOP_GO: top_q <= pwrseq_pkg::TOP_GO;
					default: top_q <= pwrseq_pkg::TOP_OFF;
				endcase
			end
		end
	end

	// any drop out of GO aborts both PLLs
	assign abort = top_q != pwrseq_pkg::TOP_GO;
	assign start[0] = !abort;
	// serial start waits for PLL1 lock
	assign start[1] = !abort && (par || pll_q[0] == pwrseq_pkg::PLL_RUN);
	assign all_done = pll_q[0] == pwrseq_pkg::PLL_RUN &&
		pll_q[1] == pwrseq_pkg::PLL_RUN;

	// One bring-up engine per PLL
	for (genvar i = 0; i < 2; i++) begin : g_pll
		// calibration then VCO wait, own counts each
		always_ff @(posedge CLOCK_IN) begin
			if (!NRST_IN) begin
				pll_q[i] <= pwrseq_pkg::PLL_IDLE;
				cnt_q[i] <= '0;
				en_q[i] <= 1'b0;
				lol_q[i] <= 1'b1;
			end else if (CE_IN) begin
				if (abort) begin
					// outputs off, engine back to idle
					pll_q[i] <= pwrseq_pkg::PLL_IDLE;
					cnt_q[i] <= '0;
					en_q[i] <= 1'b0;
					lol_q[i] <= 1'b1;
				end else begin
					case (pll_q[i])
						pwrseq_pkg::PLL_IDLE: begin
							if (start[i]) begin
								pll_q[i] <= pwrseq_pkg::PLL_CAL;
								cnt_q[i] <= cal_cnt_q[i] - W'(1);
							end
						end
						pwrseq_pkg::PLL_CAL: begin
							if (cnt_q[i] == '0) begin
								pll_q[i] <= pwrseq_pkg::PLL_VCO;
								cnt_q[i] <= vco_cnt_q[i] - W'(1);
							end else begin
								cnt_q[i] <= cnt_q[i] - W'(1);
							end
						end
						pwrseq_pkg::PLL_VCO: begin
							if (cnt_q[i] == '0) begin
								pll_q[i] <= pwrseq_pkg::PLL_LOCK;
								en_q[i] <= 1'b1;
							end else begin
								cnt_q[i] <= cnt_q[i] - W'(1);
							end
						end
						pwrseq_pkg::PLL_LOCK: begin
							// clear at PFD edge after lock
							if (sync2_q[pwrseq_pkg::SY_LK1 + i] && pfd_edge) begin
								pll_q[i] <= pwrseq_pkg::PLL_RUN;
								lol_q[i] <= 1'b0;
							end
						end
						pwrseq_pkg::PLL_RUN: begin
							// Lost lock shows at once; outputs stay up
							lol_q[i] <= !sync2_q[pwrseq_pkg::SY_LK1 + i];
						end
						default: pll_q[i] <= pwrseq_pkg::PLL_IDLE;
					endcase
				end
			end
		end

		// indicator follows PFD edge after lock
		a_lol_release: assert property (@(posedge CLOCK_IN)
			disable iff (!NRST_IN)
			CE_IN && !abort && pll_q[i] == pwrseq_pkg::PLL_LOCK &&
			sync2_q[pwrseq_pkg::SY_LK1 + i] && pfd_edge |=>
			!lol_q[i] && pll_q[i] == pwrseq_pkg::PLL_RUN)
			else $error("lock indicator not cleared");

		a_out_enable: assert property (@(posedge CLOCK_IN)
			disable iff (!NRST_IN)
			en_q[i] == (pll_q[i] == pwrseq_pkg::PLL_LOCK ||
			pll_q[i] == pwrseq_pkg::PLL_RUN))
			else $error("output enable out of step");
	end

	// Status pins, registered
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			status_q <= 2'h3;
		end else if (CE_IN) begin
			status_q[0] <= pick(ctrl_q[pwrseq_pkg::CTRL_SA_LSB +: 2],
				lol_q, all_done);
			status_q[1] <= pick(ctrl_q[pwrseq_pkg::CTRL_SB_LSB +: 2],
				lol_q, all_done);
		end
	end

	assign RDATA_OUT = rdata_q;
	assign PLL_OUT_EN_OUT = en_q;
	assign STATUS_A_OUT = status_q[0];
	assign STATUS_B_OUT = status_q[1];
	assign I2C_EN_OUT = sync2_q[pwrseq_pkg::SY_PDN];

	a_por_hold: assert property (@(posedge CLOCK_IN)
		disable iff (!NRST_IN)
		CE_IN && !por_ok |=> top_q != pwrseq_pkg::TOP_GO)
		else $error("sequence left reset without supplies");

	a_xtal_gate: assert property (@(posedge CLOCK_IN)
		disable iff (!NRST_IN)
		CE_IN && !pd && por_ok && !soft_q &&
		top_q == pwrseq_pkg::TOP_XO &&
		ctrl_q[pwrseq_pkg::CTRL_XTAL_USED] && !xo_ok |=>
		top_q == pwrseq_pkg::TOP_XO)
		else $error("crystal gate passed without swing");

	a_cal_to_vco: assert property (@(posedge CLOCK_IN)
		disable iff (!NRST_IN)
		CE_IN && !abort && pll_q[0] == pwrseq_pkg::PLL_CAL &&
		cnt_q[0] == '0 |=> pll_q[0] == pwrseq_pkg::PLL_VCO &&
		cnt_q[0] == $past(vco_cnt_q[0]) - W'(1))
		else $error("calibration end mishandled");

	a_vco_done: assert property (@(posedge CLOCK_IN)
		disable iff (!NRST_IN)
		CE_IN && !abort && pll_q[0] == pwrseq_pkg::PLL_VCO &&
		cnt_q[0] == '0 |=> en_q[0] && lol_q[0])
		else $error("outputs not raised after wait");

	a_pll2_cal: assert property (@(posedge CLOCK_IN)
		disable iff (!NRST_IN)
		CE_IN && start[1] && pll_q[1] == pwrseq_pkg::PLL_IDLE |=>
		pll_q[1] == pwrseq_pkg::PLL_CAL &&
		cnt_q[1] == $past(cal_cnt_q[1]) - W'(1))
		else $error("second calibration count wrong");

	a_serial_wait: assert property (@(posedge CLOCK_IN)
		disable iff (!NRST_IN)
		CE_IN && !par && pll_q[0] != pwrseq_pkg::PLL_RUN &&
		pll_q[1] == pwrseq_pkg::PLL_IDLE |=>
		pll_q[1] == pwrseq_pkg::PLL_IDLE)
		else $error("second PLL started before first lock");

	a_parallel_go: assert property (@(posedge CLOCK_IN)
		disable iff (!NRST_IN)
		CE_IN && par && !abort && pll_q[1] == pwrseq_pkg::PLL_IDLE |=>
		pll_q[1] == pwrseq_pkg::PLL_CAL)
		else $error("parallel start missed");

	a_pd_abort: assert property (@(posedge CLOCK_IN)
		disable iff (!NRST_IN)
		CE_IN && pd |=> top_q == pwrseq_pkg::TOP_OFF ##1
		(!CE_IN || en_q == 2'h0))
		else $error("power-down did not stop sequence");

	a_strap_load: assert property (@(posedge CLOCK_IN)
		disable iff (!NRST_IN)
		CE_IN && pdn_rise |=>
		par == $past(CFG_PINS_IN.par_start) &&
		top_q == pwrseq_pkg::TOP_POR)
		else $error("strap values not loaded");

	a_port_dark: assert property (@(posedge CLOCK_IN)
		disable iff (!NRST_IN)
		CE_IN && pd && BUS_REQ_IN.rd |-> !I2C_EN_OUT ##1 RDATA_OUT == 32'h0)
		else $error("register port live in power-down");

	a_soft_rerun: assert property (@(posedge CLOCK_IN)
		disable iff (!NRST_IN)
		CE_IN && soft_q && !pd |=> top_q == pwrseq_pkg::TOP_POR ##1
		(!CE_IN || pll_q[0] == pwrseq_pkg::PLL_IDLE))
		else $error("soft reset did not restart");

endmodule

// ### hdl/pwrseq_pkg.sv
package pwrseq_pkg;

	// Sequencer clock rate, also the internal oscillator rate
	localparam int CLK_KHZ = 10000;
	localparam int CYC_PER_US = CLK_KHZ / 1000;

	// Counter width covers the longest programmable period
	localparam int CNT_W = 22;

	// Documented period limits and recommendations, in their own units
	localparam int CAL_MIN_US = 30;
	localparam int CAL_MAX_MS = 300;
	localparam int VCO_MIN_US = 20;
	localparam int VCO_MAX_MS = 200;
	localparam int CAL_CG_US = 300;
	localparam int CAL_JC_MS = 300;
	localparam int VCO_REC_US = 400;

	// Same periods as clock counts
	localparam int CAL_MIN_CYC = CAL_MIN_US * CYC_PER_US;
	localparam int CAL_MAX_CYC = CAL_MAX_MS * CLK_KHZ;
	localparam int VCO_MIN_CYC = VCO_MIN_US * CYC_PER_US;
	localparam int VCO_MAX_CYC = VCO_MAX_MS * CLK_KHZ;
	localparam int CAL_CG_CYC = CAL_CG_US * CYC_PER_US;
	localparam int CAL_JC_CYC = CAL_JC_MS * CLK_KHZ;
	localparam int VCO_REC_CYC = VCO_REC_US * CYC_PER_US;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CAL1 = 8'h04;
	localparam logic [7:0] OFF_VCO1 = 8'h08;
	localparam logic [7:0] OFF_CAL2 = 8'h0C;
	localparam logic [7:0] OFF_VCO2 = 8'h10;
	localparam logic [7:0] OFF_STAT = 8'h14;

	// Control register fields
	localparam int CTRL_SOFT_RST = 0;
	localparam int CTRL_PAR_START = 1;
	localparam int CTRL_XTAL_USED = 2;
	localparam int CTRL_SA_LSB = 4;
	localparam int CTRL_SB_LSB = 6;

	// Control reset value: serial start, no crystal, both show PLL1 loss of lock
	localparam logic [7:0] CTRL_RST = 8'h00;

	// Status selector codes
	localparam logic [1:0] SEL_LOL1 = 2'h0;
	localparam logic [1:0] SEL_LOL2 = 2'h1;
	localparam logic [1:0] SEL_DONE = 2'h2;

	// Synchroniser lanes
	localparam int SY_PDN = 0;
	localparam int SY_POR = 1;
	localparam int SY_XO = 2;
	localparam int SY_LK1 = 3;
	localparam int SY_PFD = 5;
	localparam int SY_W = 6;

	// Top sequence, Gray along the power-up path
	typedef enum logic [1:0] {
		TOP_OFF = 2'h0,
		TOP_POR = 2'h1,
		TOP_XO = 2'h3,
		TOP_GO = 2'h2
	} top_state_t;

	// Per-PLL sequence, Gray along the bring-up path
	typedef enum logic [2:0] {
		PLL_IDLE = 3'h0,
		PLL_CAL = 3'h1,
		PLL_VCO = 3'h3,
		PLL_LOCK = 3'h2,
		PLL_RUN = 3'h6
	} pll_state_t;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	// Configuration straps
	typedef struct packed {
		logic jitter_clean;
		logic xtal_used;
		logic par_start;
	} cfg_pins_t;

endpackage

// ### verification/dual_pll_powerup_sequencer_test.sv
`timescale 1ns/10ps
module dual_pll_powerup_sequencer_test;
	// Small counts keep the run short
	localparam int CAL_MAX = 400;
	localparam int VCO_MAX = 300;
	logic clock_in;
	logic nrst_in;
	logic ce_in;
	pwrseq_pkg::bus_req_t req;
	pwrseq_pkg::cfg_pins_t cfg;
	logic [31:0] rdata;
	logic pdn_n;
	logic por_ok;
	logic xtal_ok;
	logic pin_req;
	logic pfd;
	logic [1:0] lock;
	logic [1:0] en;
	logic sta;
	logic stb;
	logic i2c_en;
	int error_cnt;
	int num_checks;
	int seed_val;
	int ta;
	int tb;
	int cyc;
	logic [31:0] rv;
	logic [21:0] n1;
	logic [21:0] m1;
	logic [21:0] n2;
	logic [21:0] m2;

	pwrseq #(.CAL_MAX_CYC(CAL_MAX), .VCO_MAX_CYC(VCO_MAX),
		.CAL_JC_CYC(CAL_MAX)) u_dut (
		.CLOCK_IN(clock_in), .NRST_IN(nrst_in), .CE_IN(ce_in),
		.BUS_REQ_IN(req), .RDATA_OUT(rdata), .POWER_DOWN_N_IN(pdn_n),
		.POR_OK_IN(por_ok), .XTAL_AMP_OK_IN(xtal_ok),
		.PLL_LOCK_IN(lock), .PFD_CLK_IN(pfd), .CFG_PINS_IN(cfg),
		.PLL_OUT_EN_OUT(en), .STATUS_A_OUT(sta), .STATUS_B_OUT(stb),
		.I2C_EN_OUT(i2c_en));

	pll_far_model u_far (.clk_in(clock_in), .pin_req_in(pin_req),
		.en_in(en), .pdn_n_out(pdn_n), .lock_out(lock), .pfd_out(pfd));

	// 10 MHz clock
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end

	// Verdict and stop
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Value compare
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
			error_cnt++;
		end
	endtask

	// Cycle count compare against a window
	task automatic check_rng(input int got, input int lo, input int hi);
		num_checks++;
		if (got < lo || got > hi) begin
			$display("wrong value t=%0t got %h exp %h", $time, got, lo);
			error_cnt++;
		end
	endtask

	// Expected control word
	function automatic logic [31:0] exp_ctrl(input logic par, input logic xo,
		input logic [1:0] sa, input logic [1:0] sb);
		return {24'h000000, sb, sa, 1'b0, xo, par, 1'b0};
	endfunction

	// One-cycle write strobe
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock_in);
		req.wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock_in);
		req <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
		@(posedge clock_in);
		req.rd <= 1'b0;
		#1 d = rdata;
	endtask

	// Watched signal by index
	function automatic logic pick(input int w);
		case (w)
			0: return en[0];
			1: return en[1];
			2: return sta;
			3: return stb;
			4: return lock[0];
			default: return lock[1];
		endcase
	endfunction

	// Bounded wait; an expired bound ends the run
	task automatic wait_for(input int w, input logic v, output int c);
		// Bound covers the strap default periods with margin
		for (c = 1; c <= 9000; c++) begin
			@(posedge clock_in);
			#1;
			if (pick(w) === v) begin
				return;
			end
		end
		error_cnt++;
		end_sim();
	endtask

	// Soft reset, then cycles until PLL1 outputs return
	task automatic run_soft(input logic [31:0] ctrl, output int t);
		int a;
		int b;
		wr_reg(pwrseq_pkg::OFF_CTRL, ctrl | 32'h00000001);
		wait_for(0, 1'b0, a);
		wait_for(0, 1'b1, b);
		t = a + b;
	endtask

	initial begin
		nrst_in = 1'b0;
		ce_in = 1'b1;
		req = '0;
		por_ok = 1'b0;
		xtal_ok = 1'b0;
		pin_req = 1'b0;
		// Straps: crystal used, serial start
		cfg = 3'h2;
		error_cnt = 0;
		num_checks = 0;
		seed_val = $urandom(47);
		repeat (6) @(posedge clock_in);
		#1;
		check_val({28'h0, en, sta, i2c_en}, 32'h00000002);
		@(posedge clock_in);
		nrst_in <= 1'b1;
		repeat (10) @(posedge clock_in);
		// Pin low: port closed
		check_val({31'h0, i2c_en}, 32'h00000000);
		wr_reg(pwrseq_pkg::OFF_CTRL, 32'h000000FF);
		rd_reg(pwrseq_pkg::OFF_CTRL, rv);
		check_val(rv, 32'h00000000);
		check_val({30'h0, en}, 32'h00000000);
		// Release pin with supply still low
		pin_req <= 1'b1;
		repeat (20) @(posedge clock_in);
		#1 check_val({31'h0, i2c_en}, 32'h00000001);
		rd_reg(pwrseq_pkg::OFF_STAT, rv);
		check_val(32'(rv[1:0] == pwrseq_pkg::TOP_XO ||
			rv[1:0] == pwrseq_pkg::TOP_GO), 32'h00000000);
		rd_reg(pwrseq_pkg::OFF_CTRL, rv);
		check_val(rv, exp_ctrl(1'b0, 1'b1, 2'h0, 2'h0));
		// Counts clamp into the programmable range
		wr_reg(pwrseq_pkg::OFF_CAL1, 32'h0000000A);
		rd_reg(pwrseq_pkg::OFF_CAL1, rv);
		check_val(rv, 32'(pwrseq_pkg::CAL_MIN_CYC));
		wr_reg(pwrseq_pkg::OFF_VCO1, 32'h00001388);
		rd_reg(pwrseq_pkg::OFF_VCO1, rv);
		check_val(rv, 32'(VCO_MAX));
		n1 = 22'(300 + $urandom_range(100));
		m1 = 22'(200 + $urandom_range(100));
		n2 = 22'(300 + $urandom_range(100));
		m2 = 22'(200 + $urandom_range(100));
		wr_reg(pwrseq_pkg::OFF_CAL1, 32'(n1));
		wr_reg(pwrseq_pkg::OFF_VCO1, 32'(m1));
		wr_reg(pwrseq_pkg::OFF_CAL2, 32'(n2));
		wr_reg(pwrseq_pkg::OFF_VCO2, 32'(m2));
		wr_reg(pwrseq_pkg::OFF_CTRL, exp_ctrl(1'b0, 1'b1, 2'h0, 2'h1));
		// Supply good, crystal still weak
		por_ok <= 1'b1;
		repeat (30) @(posedge clock_in);
		rd_reg(pwrseq_pkg::OFF_STAT, rv);
		check_val({30'h0, rv[1:0]}, 32'(pwrseq_pkg::TOP_XO));
		check_val({30'h0, en}, 32'h00000000);
		xtal_ok <= 1'b1;
		wait_for(0, 1'b1, cyc);
		// Outputs come up before the loop reports lock
		check_val({30'h0, lock[0], sta}, 32'h00000001);
		wait_for(4, 1'b1, cyc);
		wait_for(2, 1'b0, cyc);
		check_rng(cyc, 2, 16);
		check_val({31'h0, en[1]}, 32'h00000000);
		wait_for(1, 1'b1, cyc);
		check_rng(cyc, n2 + m2 - 2, n2 + m2 + 3);
		wait_for(5, 1'b1, cyc);
		wait_for(3, 1'b0, cyc);
		check_rng(cyc, 2, 16);
		// Same entry state twice: difference is the count change
		wr_reg(pwrseq_pkg::OFF_CAL1, 32'h0000012C);
		wr_reg(pwrseq_pkg::OFF_VCO1, 32'h000000C8);
		run_soft(exp_ctrl(1'b0, 1'b1, 2'h0, 2'h1), ta);
		rd_reg(pwrseq_pkg::OFF_CTRL, rv);
		check_val(rv, exp_ctrl(1'b0, 1'b1, 2'h0, 2'h1));
		wr_reg(pwrseq_pkg::OFF_CAL1, 32'(n1));
		wr_reg(pwrseq_pkg::OFF_VCO1, 32'(m1));
		run_soft(exp_ctrl(1'b0, 1'b1, 2'h0, 2'h1), tb);
		check_rng(tb - ta, n1 + m1 - 500, n1 + m1 - 500);
		// Parallel start with equal counts: both enable together
		wr_reg(pwrseq_pkg::OFF_CAL2, 32'(n1));
		wr_reg(pwrseq_pkg::OFF_VCO2, 32'(m1));
		run_soft(exp_ctrl(1'b1, 1'b1, 2'h0, 2'h1), ta);
		check_val({30'h0, en}, 32'h00000003);
		// Abort in mid-calibration, new straps
		run_soft(exp_ctrl(1'b0, 1'b1, 2'h0, 2'h1), ta);
		wr_reg(pwrseq_pkg::OFF_CTRL, 32'h00000041);
		repeat (100) @(posedge clock_in);
		pin_req <= 1'b0;
		cfg <= 3'h1;
		repeat (6) @(posedge clock_in);
		#1 check_val({29'h0, en, i2c_en}, 32'h00000000);
		rd_reg(pwrseq_pkg::OFF_CTRL, rv);
		check_val(rv, 32'h00000000);
		pin_req <= 1'b1;
		repeat (10) @(posedge clock_in);
		rd_reg(pwrseq_pkg::OFF_CTRL, rv);
		check_val(rv, exp_ctrl(1'b1, 1'b0, 2'h0, 2'h0));
		wait_for(0, 1'b1, cyc);
		// Strap reload brings back the recommended default periods
		check_rng(cyc, pwrseq_pkg::CAL_CG_CYC + pwrseq_pkg::VCO_REC_CYC - 7,
			pwrseq_pkg::CAL_CG_CYC + pwrseq_pkg::VCO_REC_CYC - 3);
		check_val({31'h0, en[0]}, 32'h00000001);
		// Unmapped place reads zero
		rd_reg(8'h20, rv);
		check_val(rv, 32'h00000000);
		end_sim();
	end
endmodule

// ### verification/pll_far_model.sv
`timescale 1ns/10ps
// Far side: host pin driver plus the two analog loops
module pll_far_model #(
	parameter int LOCK_DLY = 20,
	parameter int STAGGER = 30
) (
	input wire logic clk_in,
	input wire logic pin_req_in,
	input wire logic [1:0] en_in,
	output logic pdn_n_out,
	output logic [1:0] lock_out,
	output logic pfd_out
);
	// Cycles since each output enable rose
	int run_cnt [2];
	// Reference divider
	logic [1:0] div_q;

	// Known values before the first edge
	initial begin
		pdn_n_out = 1'b0;
		lock_out = 2'h0;
		pfd_out = 1'b0;
		div_q = 2'h0;
		run_cnt[0] = 0;
		run_cnt[1] = 0;
	end

	// Host pin toggle
	// Host moves the pin just after an edge, never mid-cycle
	always @(posedge clk_in) begin
		pdn_n_out <= pin_req_in;
	end

	// Reference runs free, period eight clocks, slower than clk/2
	always @(posedge clk_in) begin
		div_q <= div_q + 2'h1;
		if (div_q == 2'h3) begin
			pfd_out <= ~pfd_out;
		end
	end

	// Staggered loop lock
	// Loop settles some time after its outputs start; PLL2 later
	always @(posedge clk_in) begin
		for (int i = 0; i < 2; i++) begin
			if (!en_in[i]) begin
				run_cnt[i] <= 0;
				lock_out[i] <= 1'b0;
			end else begin
				run_cnt[i] <= run_cnt[i] + 1;
				lock_out[i] <= run_cnt[i] >= LOCK_DLY + i * STAGGER;
			end
		end
	end
endmodule
